// file: inc/sms_params.svh
// Constants of the sensor mode and measurement sequencer
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH

// Mode field encodings
`define SMS_MODE_SLEEP      2'h0
`define SMS_MODE_FORCED     2'h1
`define SMS_MODE_FORCED_ALT 2'h2
`define SMS_MODE_NORMAL     2'h3

// Oversampling and resolution
`define SMS_OSR_SKIP        3'h0
`define SMS_OSR_MAX         3'h5
`define SMS_RES_BASE        5'h10
`define SMS_RES_FULL        5'h14

// Values loaded into the outputs of a skipped channel
`define SMS_SKIP_TP         20'h80000
`define SMS_SKIP_H          16'h8000

// Filter field
`define SMS_FILT_OFF        3'h0
`define SMS_FILT_MAXSH      3'h4

// Channel codes towards the converter
`define SMS_CH_T            2'h0
`define SMS_CH_P            2'h1
`define SMS_CH_H            2'h2

// Reset values of the settings
`define SMS_RST_OSR         3'h0
`define SMS_RST_FILT        3'h0
`define SMS_RST_STBY        3'h0

// System clock rate in MHz
`define SMS_CLK_MHZ         10

`endif

// file: inc/sms_pkg.sv
// Types of the sensor mode and measurement sequencer
package sms_pkg;

    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_NEXT,
        ST_WAIT,
        ST_COMMIT,
        ST_STANDBY
    } sms_state_t;

    // One host write; each strobe carries the fields beside it
    typedef struct packed {
        logic       mode_wr;
        logic [1:0] mode;
        logic       hum_wr;
        logic [2:0] osrs_h;
        logic       meas_wr;
        logic [2:0] osrs_t;
        logic [2:0] osrs_p;
        logic       cfg_wr;
        logic [2:0] standby_time_select;
        logic [2:0] filter;
    } sms_wr_t;

    typedef struct packed {
        logic [19:0] temp;
        logic [19:0] press;
        logic [15:0] hum;
    } sms_data_t;

    typedef struct packed {
        logic       start;
        logic [1:0] chan;
        logic [2:0] osr;
    } sms_conv_t;

endpackage

// file: rtl/sms_filt_mem.sv
// Filter memory for the temperature and pressure channels
`timescale 1ns/10ps
module sms_filt_mem
    import sms_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // Write port
    input  wire logic        i_wr_en,
    input  wire logic        i_wr_addr,
    input  wire logic [19:0] i_wr_data,
    // Read port
    input  wire logic        i_rd_addr,
    output logic      [19:0] o_rd_data
);

    logic [19:0] mem_ff [0:1];
    logic [19:0] rd_data_ff;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            mem_ff[0] <= 20'h00000;
            mem_ff[1] <= 20'h00000;
        end
        else if (i_wr_en)
        begin
            mem_ff[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            rd_data_ff <= 20'h00000;
        else
            rd_data_ff <= mem_ff[i_rd_addr];
    end

    assign o_rd_data = rd_data_ff;

endmodule

// file: rtl/sms_sequencer.sv
// Mode control and measurement sequencing of the environmental sensor
// Operation
// - Hold logic and settings in reset until both supplies are up.
// - After power-on reset the device sits in sleep mode.
// - Core supply loss or soft reset resets; interface supply loss does not.
// - Two-bit mode field selects sleep, forced or normal only.
// - Mode writes during a measurement wait until the measurement ends.
// - While a change waits, mode and humidity writes are ignored.
// - Sleep performs no conversions; settings stay writable.
// - Forced mode measures once, stores results, returns to sleep.
// - Normal mode loops measurement and a selectable standby time.
// - Normal cycle equals measurement time plus standby time.
// - Normal mode refreshes data outputs after every measurement.
// - Measurement runs temperature, pressure, humidity, each with oversampling.
// - Filter may act on pressure and temperature, never on humidity.
// - Humidity skippable or oversampled by three-bit field; result 16 bits.
// - Pressure skippable or oversampled by three-bit field.
// - Filter on gives 20-bit pressure.
// - Filter off gives 16 plus code minus one pressure bits.
// - Skipped temperature or pressure outputs skip value, filter memory kept.
// - Filter setting write resets filter; next results pass and seed it.
`timescale 1ns/10ps
`include "sms_params.svh"
module sms_sequencer
    import sms_pkg::*;
#(
    // Standby times in microseconds for each standby_time_select code
    parameter int unsigned P_STBY_US [0:7] = '{500, 1000, 2000, 5000, 10000, 100000, 500000, 1000000}
)
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // Supply good levels from the pins
    input  wire logic        i_core_supply_ok,
    input  wire logic        i_interface_supply_ok,
    // Host side
    input  wire logic        i_soft_reset,
    input  wire sms_wr_t     i_wr,
    // Converter side
    input  wire logic        i_conv_done,
    input  wire logic [19:0] i_conv_data,
    output sms_conv_t        o_conv,
    // Status and results
    output logic             o_core_reset,
    output logic      [1:0]  o_mode,
    output logic             o_measuring,
    output logic             o_pending,
    output logic             o_data_valid,
    output sms_data_t        o_data
);

    logic [2:0]  core_sync_ff;
    logic [2:0]  io_sync_ff;
    logic        core_lvl_ff;
    logic        io_lvl_ff;
    logic        por_ok_ff;
    logic        core_reset_ff;
    logic        clr;
    sms_state_t  state_ff;
    sms_state_t  nxt_state;
    logic [1:0]  mode_ff;
    logic [1:0]  nxt_mode;
    logic        pending_ff;
    logic [1:0]  pend_mode_ff;
    logic [2:0]  osrs_t_ff;
    logic [2:0]  osrs_p_ff;
    logic [2:0]  osrs_h_ff;
    logic [2:0]  filter_ff;
    logic [2:0]  stby_sel_ff;
    logic [23:0] stby_cnt_ff;
    logic [1:0]  chan_ff;
    logic [1:0]  filt_init_ff;
    logic        measuring_ff;
    sms_conv_t   conv_ff;
    sms_data_t   stage_ff;
    sms_data_t   data_ff;
    logic        data_valid_ff;
    logic [19:0] mem_rd_data;
    logic [19:0] filt_res;
    logic        mem_wr_en;
    logic [2:0]  cur_osr;
    logic        cur_skip;
    logic        busy;
    logic        mode_take;
    logic        start_meas;

    // Legal mode codes only; the spare code acts as forced
    function automatic logic [1:0] mode_dec(input logic [1:0] m);
        if (m == `SMS_MODE_SLEEP)
            mode_dec = `SMS_MODE_SLEEP;
        else if (m == `SMS_MODE_NORMAL)
            mode_dec = `SMS_MODE_NORMAL;
        else
            mode_dec = `SMS_MODE_FORCED;
    endfunction

    function automatic logic [2:0] osr_cap(input logic [2:0] c);
        osr_cap = (c > `SMS_OSR_MAX) ? `SMS_OSR_MAX : c;
    endfunction

    // Output resolution of temperature and pressure
    function automatic logic [19:0] res_fit(input logic [19:0] v, input logic [2:0] osr, input logic filt_on);
        logic [4:0]  bits;
        logic [19:0] mask;
        bits = `SMS_RES_BASE + {2'h0, osr_cap(osr)} - 5'h01;
        mask = 20'hFFFFF << (`SMS_RES_FULL - bits);
        res_fit = filt_on ? v : (v & mask);
    endfunction

    function automatic logic [19:0] iir(input logic [19:0] old, input logic [19:0] adc, input logic [2:0] sh);
        logic signed [20:0] d;
        d = $signed({1'b0, adc}) - $signed({1'b0, old});
        d = d >>> sh;
        iir = 20'($signed({1'b0, old}) + d);
    endfunction

    function automatic logic [23:0] stby_cycles(input logic [2:0] code);
        stby_cycles = 24'(P_STBY_US[code] * `SMS_CLK_MHZ);
    endfunction

    // Supply levels pass four flip-flops; the last one changes only when the two samples before it agree
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            core_sync_ff <= 3'h0;
            io_sync_ff   <= 3'h0;
            core_lvl_ff  <= 1'b0;
            io_lvl_ff    <= 1'b0;
        end
        else
        begin
            core_sync_ff <= {core_sync_ff[1:0], i_core_supply_ok};
            io_sync_ff   <= {io_sync_ff[1:0], i_interface_supply_ok};
            if (core_sync_ff[1] == core_sync_ff[2])
                core_lvl_ff <= core_sync_ff[2];
            if (io_sync_ff[1] == io_sync_ff[2])
                io_lvl_ff <= io_sync_ff[2];
        end
    end

    // Power-on release needs both supplies; only the core supply takes it back
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            por_ok_ff <= 1'b0;
        else if (!core_lvl_ff)
            por_ok_ff <= 1'b0;
        else if (io_lvl_ff)
            por_ok_ff <= 1'b1;
    end

    assign clr = !por_ok_ff || i_soft_reset;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            core_reset_ff <= 1'b1;
        else
            core_reset_ff <= clr;
    end

    assign busy      = (state_ff == ST_NEXT) || (state_ff == ST_WAIT) || (state_ff == ST_COMMIT);
    assign mode_take = i_wr.mode_wr && !pending_ff;
    assign cur_osr   = (chan_ff == `SMS_CH_T) ? osrs_t_ff : (chan_ff == `SMS_CH_P) ? osrs_p_ff : osrs_h_ff;
    assign cur_skip  = (cur_osr == `SMS_OSR_SKIP);

    // Mode and sequence control
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_mode   = mode_ff;
        start_meas = 1'b0;
        unique case (state_ff)
            ST_SLEEP, ST_STANDBY:
            begin
                if (mode_take)
                begin
                    nxt_mode = mode_dec(i_wr.mode);
                    if (mode_dec(i_wr.mode) == `SMS_MODE_SLEEP)
                        nxt_state = ST_SLEEP;
                    else
                        start_meas = 1'b1;
                end
                else if (state_ff == ST_STANDBY && stby_cnt_ff == 24'h000000)
                    start_meas = 1'b1;
                if (start_meas)
                    nxt_state = ST_NEXT;
            end
            ST_NEXT:
            begin
                if (!cur_skip)
                    nxt_state = ST_WAIT;
                else if (chan_ff == `SMS_CH_H)
                    nxt_state = ST_COMMIT;
            end
            ST_WAIT:
            begin
                if (i_conv_done)
                    nxt_state = (chan_ff == `SMS_CH_H) ? ST_COMMIT : ST_NEXT;
            end
            ST_COMMIT:
            begin
                if (pending_ff || mode_take)
                begin
                    // A write in the closing cycle is applied like a deferred one
                    nxt_mode = pending_ff ? pend_mode_ff : mode_dec(i_wr.mode);
                    if (nxt_mode == `SMS_MODE_SLEEP)
                        nxt_state = ST_SLEEP;
                    else if (nxt_mode == `SMS_MODE_NORMAL)
                        nxt_state = ST_STANDBY;
                    else
                        nxt_state = ST_NEXT;
                end
                else if (mode_ff == `SMS_MODE_NORMAL)
                    nxt_state = ST_STANDBY;
                else
                begin
                    nxt_mode  = `SMS_MODE_SLEEP;
                    nxt_state = ST_SLEEP;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_ff <= ST_SLEEP;
            mode_ff  <= `SMS_MODE_SLEEP;
        end
        else if (clr)
        begin
            state_ff <= ST_SLEEP;
            mode_ff  <= `SMS_MODE_SLEEP;
        end
        else
        begin
            state_ff <= nxt_state;
            mode_ff  <= nxt_mode;
        end
    end

    // Deferred mode change
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            pending_ff   <= 1'b0;
            pend_mode_ff <= `SMS_MODE_SLEEP;
        end
        else if (clr)
            pending_ff <= 1'b0;
        else if (mode_take && busy && state_ff != ST_COMMIT)
        begin
            pending_ff   <= 1'b1;
            pend_mode_ff <= mode_dec(i_wr.mode);
        end
        else if (state_ff == ST_COMMIT)
            pending_ff <= 1'b0;
    end

    // Settings stay writable in every mode; humidity writes are ignored while a mode change is pending
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            osrs_t_ff   <= `SMS_RST_OSR;
            osrs_p_ff   <= `SMS_RST_OSR;
            osrs_h_ff   <= `SMS_RST_OSR;
            filter_ff   <= `SMS_RST_FILT;
            stby_sel_ff <= `SMS_RST_STBY;
        end
        else if (clr)
        begin
            osrs_t_ff   <= `SMS_RST_OSR;
            osrs_p_ff   <= `SMS_RST_OSR;
            osrs_h_ff   <= `SMS_RST_OSR;
            filter_ff   <= `SMS_RST_FILT;
            stby_sel_ff <= `SMS_RST_STBY;
        end
        else
        begin
            if (i_wr.hum_wr && !pending_ff)
                osrs_h_ff <= i_wr.osrs_h;
            if (i_wr.meas_wr)
            begin
                osrs_t_ff <= i_wr.osrs_t;
                osrs_p_ff <= i_wr.osrs_p;
            end
            if (i_wr.cfg_wr)
            begin
                filter_ff   <= i_wr.filter;
                stby_sel_ff <= i_wr.standby_time_select;
            end
        end
    end

    // Filter restart flags; a filter write wins over the seeding clear
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            filt_init_ff <= 2'h3;
        else if (clr || i_wr.cfg_wr)
            filt_init_ff <= 2'h3;
        else if (mem_wr_en)
            filt_init_ff[chan_ff[0]] <= 1'b0;
    end

    // Standby timer starts as the measurement ends
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            stby_cnt_ff <= 24'h000000;
        else if (nxt_state == ST_STANDBY && state_ff != ST_STANDBY)
            stby_cnt_ff <= stby_cycles(stby_sel_ff) - 24'h000001;
        else if (stby_cnt_ff != 24'h000000)
            stby_cnt_ff <= stby_cnt_ff - 24'h000001;
    end

    // Channel walk and converter requests
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            chan_ff <= `SMS_CH_T;
            conv_ff <= '0;
        end
        else
        begin
            conv_ff.start <= 1'b0;
            if (clr || start_meas || (state_ff == ST_COMMIT && nxt_state == ST_NEXT))
                chan_ff <= `SMS_CH_T;
            else if (state_ff == ST_NEXT && !cur_skip)
            begin
                conv_ff.start <= 1'b1;
                conv_ff.chan  <= chan_ff;
                conv_ff.osr   <= cur_osr;
            end
            else if ((state_ff == ST_NEXT || (state_ff == ST_WAIT && i_conv_done)) && chan_ff != `SMS_CH_H)
                chan_ff <= chan_ff + 2'h1;
        end
    end

    // Filter step for temperature and pressure
    always_comb
    begin
        if (filter_ff == `SMS_FILT_OFF || filt_init_ff[chan_ff[0]])
            filt_res = i_conv_data;
        else
            filt_res = iir(mem_rd_data, i_conv_data, osr_cap(filter_ff) > `SMS_FILT_MAXSH ? `SMS_FILT_MAXSH : osr_cap(filter_ff));
    end

    assign mem_wr_en = (state_ff == ST_WAIT) && i_conv_done && (chan_ff != `SMS_CH_H);

    sms_filt_mem u_filt_mem (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_wr_en   (mem_wr_en),
        .i_wr_addr (chan_ff[0]),
        .i_wr_data (filt_res),
        .i_rd_addr (chan_ff[0]),
        .o_rd_data (mem_rd_data)
    );

    // Staged results of the running measurement
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            stage_ff <= '0;
        else if (state_ff == ST_NEXT && cur_skip)
        begin
            if (chan_ff == `SMS_CH_T)
                stage_ff.temp <= `SMS_SKIP_TP;
            else if (chan_ff == `SMS_CH_P)
                stage_ff.press <= `SMS_SKIP_TP;
            else
                stage_ff.hum <= `SMS_SKIP_H;
        end
        else if (state_ff == ST_WAIT && i_conv_done)
        begin
            if (chan_ff == `SMS_CH_T)
                stage_ff.temp <= res_fit(filt_res, osrs_t_ff, filter_ff != `SMS_FILT_OFF);
            else if (chan_ff == `SMS_CH_P)
                stage_ff.press <= res_fit(filt_res, osrs_p_ff, filter_ff != `SMS_FILT_OFF);
            else
                stage_ff.hum <= i_conv_data[15:0];
        end
    end

    // Data outputs refresh at the end of every measurement
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            data_ff       <= '0;
            data_valid_ff <= 1'b0;
            measuring_ff  <= 1'b0;
        end
        else
        begin
            data_valid_ff <= (state_ff == ST_COMMIT) && !clr;
            measuring_ff  <= (nxt_state != ST_SLEEP) && (nxt_state != ST_STANDBY) && !clr;
            if (clr)
                data_ff <= '0;
            else if (state_ff == ST_COMMIT)
                data_ff <= stage_ff;
        end
    end

    assign o_conv       = conv_ff;
    assign o_core_reset = core_reset_ff;
    assign o_mode       = mode_ff;
    assign o_measuring  = measuring_ff;
    assign o_pending    = pending_ff;
    assign o_data_valid = data_valid_ff;
    assign o_data       = data_ff;

    chk_por_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !por_ok_ff |=> state_ff == ST_SLEEP && mode_ff == `SMS_MODE_SLEEP && o_core_reset)
        else $error("activity while power-on reset held");
    chk_sleep_after_por: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(por_ok_ff) |-> state_ff == ST_SLEEP && !o_conv.start)
        else $error("not in sleep after power-on release");
    chk_io_no_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        por_ok_ff && core_lvl_ff && !io_lvl_ff |=> por_ok_ff)
        else $error("interface supply loss caused reset");
    chk_mode_legal: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_mode != `SMS_MODE_FORCED_ALT)
        else $error("illegal mode code held");
    chk_defer_mode: assert property (@(posedge i_clk_sys) disable iff (i_rst || clr)
        mode_take && busy && state_ff != ST_COMMIT |=> pending_ff && $stable(mode_ff))
        else $error("mode change applied during measurement");
    chk_ignore_hum: assert property (@(posedge i_clk_sys) disable iff (i_rst || clr)
        pending_ff && i_wr.hum_wr |=> $stable(osrs_h_ff))
        else $error("humidity write taken while change pending");
    chk_sleep_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_ff == ST_SLEEP ##1 state_ff == ST_SLEEP |-> !o_conv.start)
        else $error("conversion started in sleep");
    chk_forced_back: assert property (@(posedge i_clk_sys) disable iff (i_rst || clr)
        state_ff == ST_COMMIT && !pending_ff && !mode_take && mode_ff == `SMS_MODE_FORCED
        |=> state_ff == ST_SLEEP && mode_ff == `SMS_MODE_SLEEP && o_data_valid)
        else $error("forced mode did not return to sleep");
    chk_normal_loop: assert property (@(posedge i_clk_sys) disable iff (i_rst || clr)
        state_ff == ST_COMMIT && !pending_ff && !mode_take && mode_ff == `SMS_MODE_NORMAL
        |=> state_ff == ST_STANDBY && stby_cnt_ff == stby_cycles(stby_sel_ff) - 24'h000001)
        else $error("normal mode did not enter standby");
    chk_skip_value: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_ff == ST_NEXT && chan_ff == `SMS_CH_P && osrs_p_ff == `SMS_OSR_SKIP && !clr
        |=> stage_ff.press == `SMS_SKIP_TP && !$past(mem_wr_en))
        else $error("skipped pressure not loaded with skip value");

    cov_forced_done: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        state_ff == ST_COMMIT && mode_ff == `SMS_MODE_FORCED);
    cov_normal_wrap: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        state_ff == ST_STANDBY ##1 state_ff == ST_NEXT);
    cov_pending: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        pending_ff && state_ff == ST_COMMIT);

endmodule

// file: testbench/sms_conv_model.sv
// Converter model that answers each conversion request after a set delay
`timescale 1ns/10ps
module sms_conv_model
    import sms_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // Request and answer shaping
    input  wire sms_conv_t   i_conv,
    input  wire logic [3:0]  i_delay,
    input  wire logic [19:0] i_bias,
    // Answer
    output logic             o_conv_done,
    output logic      [19:0] o_conv_data
);
    logic [3:0] cnt_ff;
    logic [1:0] chan_ff;
    logic       busy_ff;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            busy_ff     <= 1'b0;
            cnt_ff      <= 4'h0;
            chan_ff     <= 2'h0;
            o_conv_done <= 1'b0;
            o_conv_data <= 20'h5A5A5;
        end
        else
        begin
            o_conv_done <= 1'b0;
            // Data lines toggle outside the done cycle
            o_conv_data <= ~o_conv_data;
            if (i_conv.start)
            begin
                busy_ff <= 1'b1;
                cnt_ff  <= i_delay;
                chan_ff <= i_conv.chan;
            end
            else if (busy_ff && cnt_ff == 4'h0)
            begin
                busy_ff     <= 1'b0;
                o_conv_done <= 1'b1;
                o_conv_data <= (chan_ff == 2'h0 ? 20'hABCDE : chan_ff == 2'h1 ? 20'h12347 : 20'h0BEEF) + i_bias;
            end
            else if (busy_ff)
            begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench of the mode and measurement sequencer
`timescale 1ns/10ps
module tb_top
    import sms_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic core_ok = 1'b0;
    logic if_ok = 1'b0;
    logic i_soft_reset = 1'b0;
    sms_wr_t i_wr = '0;
    logic conv_done;
    logic [19:0] conv_data;
    logic [3:0] delay = 4'h1;
    logic [19:0] bias = 20'h0;
    sms_conv_t conv;
    logic o_core_reset, o_measuring, o_pending, o_data_valid;
    logic [1:0] o_mode;
    sms_data_t o_data;
    int mismatches = 0;
    int n_tests = 0;
    int n_start = 0;

    always #50 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys)
    begin
        if (conv.start === 1'b1)
        begin
            n_start++;
            chk(20'(conv.osr != 3'h0), 20'h1);
        end
    end

    sms_sequencer #(.P_STBY_US('{1, 2, 3, 4, 5, 6, 7, 8})) u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_core_supply_ok(core_ok), .i_interface_supply_ok(if_ok), .i_soft_reset(i_soft_reset), .i_wr(i_wr),
        .i_conv_done(conv_done), .i_conv_data(conv_data), .o_conv(conv), .o_core_reset(o_core_reset),
        .o_mode(o_mode), .o_measuring(o_measuring), .o_pending(o_pending), .o_data_valid(o_data_valid),
        .o_data(o_data));
    sms_conv_model u_conv (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_conv(conv), .i_delay(delay),
        .i_bias(bias), .o_conv_done(conv_done), .o_conv_data(conv_data));

    task tick();
        @(posedge i_clk_sys);
        #10;
    endtask

    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        n_tests++;
        if (g !== e)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            mismatches++;
        end
    endtask

    task automatic put(input sms_wr_t w);
        i_wr = w;
        tick();
        i_wr = '0;
        tick();
    endtask

    task automatic set_mode(input logic [1:0] m);
        sms_wr_t w;
        w = '0;
        w.mode_wr = 1'b1;
        w.mode = m;
        put(w);
    endtask

    task automatic set_osr(input logic [2:0] t, input logic [2:0] p, input logic [2:0] h);
        sms_wr_t w;
        w = '0;
        w.meas_wr = 1'b1;
        w.hum_wr = 1'b1;
        w.osrs_t = t;
        w.osrs_p = p;
        w.osrs_h = h;
        put(w);
    endtask

    task automatic set_cfg(input logic [2:0] sb, input logic [2:0] f);
        sms_wr_t w;
        w = '0;
        w.cfg_wr = 1'b1;
        w.standby_time_select = sb;
        w.filter = f;
        put(w);
    endtask

    task automatic wait_valid();
        int k;
        k = 0;
        while (o_data_valid !== 1'b1 && k < 400)
        begin
            tick();
            k++;
        end
        chk(20'(k < 400), 20'h1);
    endtask

    task automatic shot(input logic [2:0] t, input logic [2:0] p, input logic [2:0] h);
        set_osr(t, p, h);
        set_mode(2'h1);
        wait_valid();
    endtask

    task automatic t_power_up();
        repeat (10) tick();
        chk(20'(o_core_reset), 20'h1);
        core_ok = 1'b1;
        repeat (10) tick();
        chk(20'(o_core_reset), 20'h1);
        if_ok = 1'b1;
        repeat (10) tick();
        chk(20'(o_core_reset), 20'h0);
        chk(20'(o_mode), 20'h0);
        chk(20'(n_start), 20'h0);
        $display("power up test done");
    endtask

    task automatic t_forced();
        shot(3'h5, 3'h3, 3'h1);
        chk(o_data.temp, 20'hABCDE);
        chk(o_data.press, 20'h12344);
        chk(20'(o_data.hum), 20'h0BEEF);
        tick();
        chk(20'(o_mode), 20'h0);
        shot(3'h0, 3'h0, 3'h0);
        chk(o_data.temp, 20'h80000);
        chk(o_data.press, 20'h80000);
        chk(20'(o_data.hum), 20'h08000);
        set_mode(2'h2);
        chk(20'(o_mode), 20'h1);
        wait_valid();
        $display("forced test done");
    endtask

    task automatic t_filter();
        delay = 4'h9;
        set_cfg(3'h0, 3'h1);
        shot(3'h5, 3'h5, 3'h1);
        chk(o_data.press, 20'h12347);
        bias = 20'h00100;
        shot(3'h5, 3'h5, 3'h1);
        chk(o_data.press, 20'h123C7);
        chk(o_data.temp, 20'hABD5E);
        chk(20'(o_data.hum), 20'h0BFEF);
        bias = 20'h00300;
        shot(3'h5, 3'h0, 3'h1);
        chk(o_data.press, 20'h80000);
        shot(3'h5, 3'h5, 3'h1);
        chk(o_data.press, 20'h12507);
        bias = 20'h0;
        delay = 4'h1;
        set_cfg(3'h1, 3'h0);
        $display("filter test done");
    endtask

    task automatic t_defer_normal();
        int k;
        set_osr(3'h5, 3'h5, 3'h1);
        set_mode(2'h1);
        chk(20'(o_measuring), 20'h1);
        set_mode(2'h3);
        chk(20'(o_pending), 20'h1);
        set_osr(3'h5, 3'h5, 3'h0);
        set_mode(2'h0);
        wait_valid();
        tick();
        chk(20'(o_mode), 20'h3);
        k = 1;
        while (o_data_valid !== 1'b1 && k < 200)
        begin
            tick();
            k++;
        end
        chk(20'(k > 20 && k < 80), 20'h1);
        chk(20'(o_data.hum), 20'h0BEEF);
        wait_valid();
        set_mode(2'h0);
        repeat (60) tick();
        chk(20'(o_mode), 20'h0);
        $display("defer and normal test done");
    endtask

    task automatic t_resets();
        i_soft_reset = 1'b1;
        tick();
        chk(20'(o_core_reset), 20'h1);
        i_soft_reset = 1'b0;
        repeat (4) tick();
        chk(20'(o_core_reset), 20'h0);
        chk(o_data.temp, 20'h0);
        if_ok = 1'b0;
        repeat (20) tick();
        chk(20'(o_core_reset), 20'h0);
        if_ok = 1'b1;
        core_ok = 1'b0;
        repeat (10) tick();
        chk(20'(o_core_reset), 20'h1);
        $display("reset test done");
    endtask

    task give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge i_clk_sys);
        #10;
        i_rst = 1'b0;
        t_power_up();
        t_forced();
        t_filter();
        t_defer_normal();
        t_resets();
        give_verdict();
    end

    initial
    begin
        #3000000;
        mismatches++;
        give_verdict();
    end
endmodule
